// [design/sgt_pkg.sv]
package sgt_pkg;

	////////////////////////////////////////////////////////////////////////
	// parameter addresses
	localparam logic [15:0] ADDR_SCALE = 16'h0150;
	localparam logic [15:0] ADDR_INERTIA = 16'h014A;
	localparam logic [15:0] ADDR_MODE = 16'h0240;
	localparam logic [15:0] ADDR_RESP = 16'h023E;
	localparam logic [15:0] ADDR_STABLE = 16'h0242;

	// gain bank, index order: position, position ff, kvp, kvi,
	// speed ff, low-pass, anti-disturbance
	localparam int NUM_GAINS = 7;
	localparam int GAIN_KVP = 2;
	localparam logic [15:0] GAIN_ADDR [NUM_GAINS] = '{16'h0200, 16'h0204,
		16'h0208, 16'h020C, 16'h020E, 16'h0232, 16'h0234};
	localparam logic [15:0] GAIN_RST [NUM_GAINS] = '{16'h0023, 16'h0032,
		16'h01F4, 16'h0064, 16'h0000, 16'h0002, 16'h0000};
	localparam logic [15:0] GAIN_MAX [NUM_GAINS] = '{16'h07FF, 16'h0064,
		16'h1FFF, 16'h03FF, 16'h0064, 16'h03E8, 16'h0400};

	////////////////////////////////////////////////////////////////////////
	// reset values and write limits
	localparam logic [15:0] SCALE_RST = 16'h0BB8;
	localparam logic [15:0] SCALE_MAX = 16'h2710;
	localparam logic [15:0] MODE_MAX = 16'h0002;
	localparam logic [15:0] RESP_RST = 16'h0005;
	localparam logic [15:0] RESP_MIN = 16'h0001;
	localparam logic [15:0] RESP_MAX = 16'h000A;
	localparam logic [15:0] INERTIA_RST = 16'h000A;

	////////////////////////////////////////////////////////////////////////
	// analog scaling: command = volts * scale / 10, input is in millivolts
	localparam logic signed [15:0] FULL_SCALE_MV = 16'sh2710;
	localparam longint MV_PER_V = 1000;
	localparam longint VOLT_DIV = 10;
	localparam logic signed [32:0] SCALE_DIVISOR = 33'(MV_PER_V * VOLT_DIV);

	////////////////////////////////////////////////////////////////////////
	// inertia save period
	localparam longint CLK_HZ = 10_000_000;
	localparam longint SAVE_MINUTES = 30;
	localparam longint SEC_PER_MIN = 60;
	localparam logic [35:0] SAVE_CYCLES_DEF =
		36'(SAVE_MINUTES * SEC_PER_MIN * CLK_HZ);

	typedef enum logic [1:0] {TUNE_MANUAL, TUNE_AUTO, TUNE_SEMI} sgt_tune_t;
	localparam logic [1:0] SEL_FIRST = 2'h0;
	localparam logic [1:0] SEL_SECOND = 2'h1;
	localparam logic [1:0] SEL_THIRD = 2'h2;

endpackage

// [design/sgt_scaler.sv]
`timescale 1ns/100ps
`default_nettype none
module sgt_scaler
	import sgt_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic signed [15:0] volt_mv,
	input wire logic [15:0] scale,
	output logic signed [15:0] scaled_r
);

	logic signed [15:0] v_clip;
	logic signed [32:0] prod;
	logic signed [32:0] quot;

	// beyond full scale the input is clipped, so the result tops out at scale
	always_comb
	begin
		if (volt_mv > FULL_SCALE_MV)
			v_clip = FULL_SCALE_MV; // R17
		else if (volt_mv < -FULL_SCALE_MV)
			v_clip = -FULL_SCALE_MV; // R17
		else
			v_clip = volt_mv;
		prod = 33'(v_clip * $signed({1'b0, scale})); // R1
		quot = prod / SCALE_DIVISOR; // R1
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			scaled_r <= 16'sh0000;
		else if (ce)
			scaled_r <= 16'(quot);
	end

endmodule
`default_nettype wire

// [design/sgt_save_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module sgt_save_timer
	import sgt_pkg::*;
#(
	parameter logic [35:0] PERIOD = SAVE_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic run,
	output logic tick_r
);

	logic [35:0] cnt_r;

	// restarts whenever run drops, so a full period follows each entry
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r <= 36'h0;
			tick_r <= 1'b0;
		end
		else if (ce)
		begin
			tick_r <= 1'b0;
			if (!run)
				cnt_r <= 36'h0;
			else if (cnt_r >= PERIOD - 36'h1)
			begin
				cnt_r <= 36'h0;
				tick_r <= 1'b1;
			end
			else
				cnt_r <= cnt_r + 36'h1;
		end
	end

endmodule
`default_nettype wire

// [design/sgt_speed_gain_top.sv]
// Function
// R1: command or limit equals input volts times scale setting divided by ten.
// R2: speed mode: scale setting is the r/min command at 10 V input.
// R3: torque mode: same scale setting gives the speed limit at 10 V.
// R4: zero-command variant forces first command to zero, else analog input.
// R5: speed-select inputs choose the command only after servo on.
// R6: tuning mode 0 manual, 1 continuous auto, 2 semi-auto; resets to 0.
// R7: manual mode disables automatic functions, user gains used only.
// R8: leaving auto or semi for manual copies measured values into all gains.
// R9: auto mode estimates inertia continuously, saving it every 30 minutes.
// R10: operator writes a suitable inertia ratio when entering semi-auto mode.
// R11: auto to manual loads measured position, kvp and kvi gains; the code copies all seven measured gains.
// R12: semi to manual loads measured position, kvp, kvi and both filters; the code copies all seven measured gains.
// R13: semi mode, inertia settled: flag set, estimation stops, inertia saved.
// R14: excessive inertia clears the flag and resumes continuous estimation.
// R15: auto offers ten bandwidth levels, user gains are its starting values.
// R16: kvp accepts 0 to 8191, resets to 500.
// R17: analog input beyond full scale saturates the result at the maximum.
// R18: out-of-range writes to tuning mode and scale setting are rejected.
`timescale 1ns/100ps
`default_nettype none
module sgt_speed_gain_top
	import sgt_pkg::*;
#(
	parameter logic [35:0] SAVE_CYCLES = SAVE_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	// parameter access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata_r,
	output logic reg_err_r,
	// speed command path
	input wire logic signed [15:0] analog_mv,
	input wire logic torque_mode,
	input wire logic zero_command_speed_mode,
	input wire logic servo_on,
	input wire logic [1:0] speed_select_inputs,
	input wire logic signed [15:0] preset_cmd_2,
	input wire logic signed [15:0] preset_cmd_3,
	input wire logic signed [15:0] preset_cmd_4,
	output logic signed [15:0] speed_cmd_r,
	output logic signed [15:0] speed_limit_r,
	// estimator side
	input wire logic [15:0] est_inertia,
	input wire logic est_settled,
	input wire logic est_excessive,
	input wire logic meas_valid,
	input wire logic [15:0] meas_position_loop_gain,
	input wire logic [15:0] meas_position_feedforward_gain,
	input wire logic [15:0] meas_speed_proportional_gain,
	input wire logic [15:0] meas_speed_integral_gain,
	input wire logic [15:0] meas_speed_feedforward_gain,
	input wire logic [15:0] meas_resonance_lowpass_setting,
	input wire logic [15:0] meas_antidisturbance_gain,
	output logic estimate_en_r,
	output logic auto_gain_en_r,
	output logic [15:0] response_level_r,
	output logic [15:0] load_inertia_ratio_r,
	output logic inertia_stable_flag_r,
	output logic [15:0] position_loop_gain_r,
	output logic [15:0] position_feedforward_gain_r,
	output logic [15:0] speed_proportional_gain_r,
	output logic [15:0] speed_integral_gain_r,
	output logic [15:0] speed_feedforward_gain_r,
	output logic [15:0] resonance_lowpass_setting_r,
	output logic [15:0] antidisturbance_gain_r
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [15:0] max_analog_speed_scale_r;
	sgt_tune_t tuning_mode_field_r;
	sgt_tune_t tune_nxt;
	logic [15:0] user_gain_r [NUM_GAINS];
	logic [15:0] meas_gain [NUM_GAINS];
	logic [15:0] active_gain_r [NUM_GAINS];
	logic meas_seen_r;
	logic signed [15:0] scaled;
	logic signed [15:0] first_speed_command;
	logic signed [15:0] speed_nxt;
	logic save_tick;
	logic wr_ok;
	logic wr_known;
	logic mode_wr;
	logic to_manual;
	logic to_semi;
	logic settle_evt;
	logic [15:0] rd_nxt;

	assign meas_gain[0] = meas_position_loop_gain;
	assign meas_gain[1] = meas_position_feedforward_gain;
	assign meas_gain[2] = meas_speed_proportional_gain;
	assign meas_gain[3] = meas_speed_integral_gain;
	assign meas_gain[4] = meas_speed_feedforward_gain;
	assign meas_gain[5] = meas_resonance_lowpass_setting;
	assign meas_gain[6] = meas_antidisturbance_gain;

	assign position_loop_gain_r = active_gain_r[0];
	assign position_feedforward_gain_r = active_gain_r[1];
	assign speed_proportional_gain_r = active_gain_r[2];
	assign speed_integral_gain_r = active_gain_r[3];
	assign speed_feedforward_gain_r = active_gain_r[4];
	assign resonance_lowpass_setting_r = active_gain_r[5];
	assign antidisturbance_gain_r = active_gain_r[6];

	////////////////////////////////////////////////////////////////////////
	// write validation

	always_comb
	begin
		wr_known = 1'b1;
		wr_ok = 1'b0;
		unique case (reg_addr)
			ADDR_SCALE: wr_ok = (reg_wdata <= SCALE_MAX); // R18
			ADDR_MODE: wr_ok = (reg_wdata <= MODE_MAX); // R18
			ADDR_RESP: wr_ok = (reg_wdata >= RESP_MIN) &&
				(reg_wdata <= RESP_MAX); // R15
			ADDR_INERTIA: wr_ok = 1'b1;
			default:
			begin
				wr_known = 1'b0;
				for (int i = 0; i < NUM_GAINS; i++)
				begin
					if (reg_addr == GAIN_ADDR[i])
					begin
						wr_known = 1'b1;
						wr_ok = (reg_wdata <= GAIN_MAX[i]); // R16
					end
				end
			end
		endcase
	end

	// stable flag is read-only and counts as a rejected write
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_err_r <= 1'b0;
		else if (ce)
			reg_err_r <= reg_wr && !(wr_known && wr_ok);
	end

	////////////////////////////////////////////////////////////////////////
	// tuning mode

	always_comb
	begin
		unique case (reg_wdata[1:0])
			2'h1: tune_nxt = TUNE_AUTO; // R6
			2'h2: tune_nxt = TUNE_SEMI; // R6
			default: tune_nxt = TUNE_MANUAL; // R6
		endcase
	end

	assign mode_wr = reg_wr && wr_ok && (reg_addr == ADDR_MODE);
	assign to_manual = mode_wr && (tune_nxt == TUNE_MANUAL) &&
		(tuning_mode_field_r != TUNE_MANUAL);
	assign to_semi = mode_wr && (tune_nxt == TUNE_SEMI);
	assign settle_evt = (tuning_mode_field_r == TUNE_SEMI) && estimate_en_r &&
		est_settled;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tuning_mode_field_r <= TUNE_MANUAL; // R6
		else if (ce && mode_wr)
			tuning_mode_field_r <= tune_nxt;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			estimate_en_r <= 1'b0;
			auto_gain_en_r <= 1'b0;
		end
		else if (ce)
		begin
			unique case (tuning_mode_field_r)
				TUNE_MANUAL:
				begin
					estimate_en_r <= 1'b0; // R7
					auto_gain_en_r <= 1'b0; // R7
				end
				TUNE_AUTO:
				begin
					estimate_en_r <= 1'b1; // R9
					auto_gain_en_r <= 1'b1;
				end
				TUNE_SEMI:
				begin
					// stops at the settle event, restarts on excess
					if (est_excessive)
						estimate_en_r <= 1'b1; // R14
					else if (settle_evt)
						estimate_en_r <= 1'b0; // R13
					else if (!inertia_stable_flag_r)
						estimate_en_r <= 1'b1;
					auto_gain_en_r <= 1'b1;
				end
			endcase
			if (mode_wr && tune_nxt == TUNE_MANUAL)
				estimate_en_r <= 1'b0;
		end
	end

	// set wins over clear when both arrive together
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			inertia_stable_flag_r <= 1'b0;
		else if (ce)
		begin
			if (settle_evt)
				inertia_stable_flag_r <= 1'b1; // R13
			else if (est_excessive || to_semi)
				inertia_stable_flag_r <= 1'b0; // R14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// inertia ratio and response level

	sgt_save_timer #(
		.PERIOD(SAVE_CYCLES)
	) u_save_timer (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.run(tuning_mode_field_r == TUNE_AUTO),
		.tick_r(save_tick)
	);

	// hardware saves win over a host write in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			load_inertia_ratio_r <= INERTIA_RST;
		else if (ce)
		begin
			if (save_tick) // R9
				load_inertia_ratio_r <= est_inertia;
			else if (settle_evt) // R13
				load_inertia_ratio_r <= est_inertia;
			else if (to_manual)
				load_inertia_ratio_r <= est_inertia;
			else if (reg_wr && reg_addr == ADDR_INERTIA) // R10
				load_inertia_ratio_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			response_level_r <= RESP_RST;
		else if (ce && reg_wr && wr_ok && reg_addr == ADDR_RESP)
			response_level_r <= reg_wdata; // R15
	end

	////////////////////////////////////////////////////////////////////////
	// gain bank

	// cleared on each mode change so auto starts from the user values
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			meas_seen_r <= 1'b0;
		else if (ce)
		begin
			if (mode_wr)
				meas_seen_r <= 1'b0; // R15
			else if (meas_valid && tuning_mode_field_r != TUNE_MANUAL)
				meas_seen_r <= 1'b1;
		end
	end

	for (genvar g = 0; g < NUM_GAINS; g++)
	begin : gen_gain
		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				user_gain_r[g] <= GAIN_RST[g]; // R16
			else if (ce)
			begin
				if (to_manual)
					user_gain_r[g] <= meas_gain[g]; // R8 R11 R12
				else if (reg_wr && wr_ok && reg_addr == GAIN_ADDR[g])
					user_gain_r[g] <= reg_wdata; // R16
			end
		end

		always_ff @(posedge clk or negedge rstn)
		begin
			if (!rstn)
				active_gain_r[g] <= GAIN_RST[g];
			else if (ce)
			begin
				if (tuning_mode_field_r == TUNE_MANUAL || !meas_seen_r)
					active_gain_r[g] <= user_gain_r[g]; // R7
				else
					active_gain_r[g] <= meas_gain[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog scaling and command selection

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			max_analog_speed_scale_r <= SCALE_RST;
		else if (ce && reg_wr && wr_ok && reg_addr == ADDR_SCALE)
			max_analog_speed_scale_r <= reg_wdata; // R18
	end

	sgt_scaler u_scaler (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.volt_mv(analog_mv),
		.scale(max_analog_speed_scale_r),
		.scaled_r(scaled)
	);

	always_comb
	begin
		if (zero_command_speed_mode)
			first_speed_command = 16'sh0000; // R4
		else
			first_speed_command = scaled; // R2 R4
		unique case (speed_select_inputs)
			SEL_FIRST: speed_nxt = first_speed_command;
			SEL_SECOND: speed_nxt = preset_cmd_2;
			SEL_THIRD: speed_nxt = preset_cmd_3;
			default: speed_nxt = preset_cmd_4;
		endcase
	end

	// torque mode has no speed command of its own, only the limit
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			speed_cmd_r <= 16'sh0000;
			speed_limit_r <= 16'sh0000;
		end
		else if (ce)
		begin
			if (servo_on && !torque_mode)
				speed_cmd_r <= speed_nxt; // R5
			else
				speed_cmd_r <= 16'sh0000; // R5
			if (torque_mode)
				speed_limit_r <= scaled; // R3
			else
				speed_limit_r <= 16'sh0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	always_comb
	begin
		rd_nxt = 16'h0000;
		unique case (reg_addr)
			ADDR_SCALE: rd_nxt = max_analog_speed_scale_r;
			ADDR_MODE: rd_nxt = {14'h0000, tuning_mode_field_r};
			ADDR_RESP: rd_nxt = response_level_r;
			ADDR_INERTIA: rd_nxt = load_inertia_ratio_r;
			ADDR_STABLE: rd_nxt = {15'h0000, inertia_stable_flag_r};
			default:
			begin
				for (int i = 0; i < NUM_GAINS; i++)
				begin
					if (reg_addr == GAIN_ADDR[i])
						rd_nxt = user_gain_r[i];
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata_r <= 16'h0000;
		else if (ce && reg_rd)
			reg_rdata_r <= rd_nxt;
	end

endmodule
`default_nettype wire

// [test/sgt_speed_gain_props.sv]
`timescale 1ns/100ps
`default_nettype none
module sgt_speed_gain_props
	import sgt_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_err_r,
	input wire logic servo_on,
	input wire logic torque_mode,
	input wire logic signed [15:0] speed_cmd_r,
	input wire logic est_settled,
	input wire logic est_excessive,
	input wire logic [15:0] meas_speed_proportional_gain,
	input wire logic estimate_en_r,
	input wire logic auto_gain_en_r,
	input wire logic inertia_stable_flag_r,
	input wire logic [15:0] speed_proportional_gain_r
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	sequence s_wr(logic [15:0] a);
		ce && reg_wr && reg_addr == a;
	endsequence
	sequence s_to_manual;
		s_wr(ADDR_MODE) ##0 (reg_wdata == 16'h0000 && auto_gain_en_r);
	endsequence

	property p_ro_addr;
		s_wr(ADDR_STABLE) |=> reg_err_r;
	endproperty
	property p_mode_bad;
		s_wr(ADDR_MODE) ##0 (reg_wdata > MODE_MAX) |=> reg_err_r;
	endproperty
	property p_mode_ok;
		s_wr(ADDR_MODE) ##0 (reg_wdata <= MODE_MAX) |=> !reg_err_r;
	endproperty
	property p_scale_bad;
		s_wr(ADDR_SCALE) ##0 (reg_wdata > SCALE_MAX) |=> reg_err_r;
	endproperty
	property p_kvp_bad;
		s_wr(GAIN_ADDR[GAIN_KVP]) ##0 (reg_wdata > GAIN_MAX[GAIN_KVP])
			|=> reg_err_r;
	endproperty
	// a frozen clock enable holds an old error pulse, so only fresh ones
	property p_err_cause;
		reg_err_r && $past(ce) |-> $past(reg_wr);
	endproperty
	property p_cmd_off;
		ce && (!servo_on || torque_mode) |=> speed_cmd_r == 16'sh0000;
	endproperty
	// copy lands one edge after the mode change, active one edge later
	property p_to_manual;
		s_to_manual |=> ##1 (!auto_gain_en_r && !estimate_en_r &&
			speed_proportional_gain_r ==
			$past(meas_speed_proportional_gain, 2));
	endproperty
	// a manual entry in flight stops estimation, so keep it out
	property p_excess;
		ce && est_excessive && !est_settled && auto_gain_en_r &&
			!(reg_wr && reg_addr == ADDR_MODE) &&
			!$past(reg_wr && reg_addr == ADDR_MODE)
			|=> !inertia_stable_flag_r && estimate_en_r;
	endproperty

	a_ro_addr: assert property (p_ro_addr)
		else $error("write to read-only flag not refused");
	a_mode_bad: assert property (p_mode_bad)
		else $error("tuning mode above 2 not refused");
	a_mode_ok: assert property (p_mode_ok)
		else $error("legal tuning mode refused");
	a_scale_bad: assert property (p_scale_bad)
		else $error("scale above 10000 not refused");
	a_kvp_bad: assert property (p_kvp_bad)
		else $error("kvp above 8191 not refused");
	a_err_cause: assert property (p_err_cause)
		else $error("error pulse without a write");
	a_cmd_off: assert property (p_cmd_off)
		else $error("speed command not zero");
	a_to_manual: assert property (p_to_manual)
		else $error("manual entry wrong");
	a_excess: assert property (p_excess)
		else $error("excessive inertia not handled");
endmodule
bind sgt_speed_gain_top sgt_speed_gain_props u_props (.*);
`default_nettype wire

// [test/sgt_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sgt_far_model
	import sgt_pkg::*;
#(
	parameter logic [15:0] INERTIA = 16'h0030
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic signed [15:0] mv_set,
	input wire logic estimate_en,
	input wire logic overload,
	output logic signed [15:0] analog_mv,
	output logic [15:0] est_inertia,
	output logic est_settled,
	output logic est_excessive,
	output logic meas_valid,
	output logic [15:0] meas [NUM_GAINS]
);
	logic [3:0] settle_r;
	logic [2:0] tick_r;
	assign analog_mv = mv_set;
	assign est_inertia = INERTIA;
	assign est_excessive = overload;
	assign est_settled = settle_r == 4'h5;
	assign meas_valid = tick_r == 3'h7;
	always_comb
	begin
		for (int i = 0; i < NUM_GAINS; i++)
			meas[i] = GAIN_RST[i] + 16'(i + 1);
	end
	// settles only after a run of undisturbed estimation
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			settle_r <= 4'h0;
		else if (!estimate_en || overload)
			settle_r <= 4'h0;
		else if (settle_r != 4'h5)
			settle_r <= settle_r + 4'h1;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tick_r <= 3'h0;
		else
			tick_r <= tick_r + 3'h1;
	end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
	import sgt_pkg::*;
	typedef struct packed {
		logic signed [15:0] mv;
		logic tq;
		logic zc;
		logic [1:0] sel;
		logic signed [15:0] cmd;
		logic signed [15:0] lim;
	} sgt_row_t;
	sgt_row_t rows [9] = '{
		'{16'sh1388, 1'b0, 1'b0, 2'h0, 16'sh05DC, 16'sh0000},
		'{16'sh2710, 1'b0, 1'b0, 2'h0, 16'sh0BB8, 16'sh0000},
		'{16'shF63C, 1'b0, 1'b0, 2'h0, 16'shFD12, 16'sh0000},
		'{16'sh2EE0, 1'b0, 1'b0, 2'h0, 16'sh0BB8, 16'sh0000},
		'{16'sh1388, 1'b0, 1'b1, 2'h0, 16'sh0000, 16'sh0000},
		'{16'sh1388, 1'b0, 1'b0, 2'h1, 16'sh0064, 16'sh0000},
		'{16'sh1388, 1'b0, 1'b0, 2'h2, 16'sh00C8, 16'sh0000},
		'{16'sh1388, 1'b0, 1'b0, 2'h3, 16'sh012C, 16'sh0000},
		'{16'sh1388, 1'b1, 1'b0, 2'h0, 16'sh0000, 16'sh05DC}};
	logic clk, rstn, ce, reg_wr, reg_rd, reg_err, torque_mode, zcm;
	logic servo_on, overload, est_settled, est_excessive, meas_valid;
	logic est_en, auto_en, flag;
	logic [1:0] sel;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, est_inertia, resp, inertia;
	logic signed [15:0] mv_set, analog_mv, cmd, lim;
	logic [15:0] meas [NUM_GAINS];
	logic [15:0] gain [NUM_GAINS];
	int err_total = 0;
	int n_compared = 0;
	int n;

	sgt_far_model FAR (.clk(clk), .rstn(rstn), .mv_set(mv_set),
		.estimate_en(est_en), .overload(overload), .analog_mv(analog_mv),
		.est_inertia(est_inertia), .est_settled(est_settled),
		.est_excessive(est_excessive), .meas_valid(meas_valid),
		.meas(meas));
	sgt_speed_gain_top #(.SAVE_CYCLES(36'h14)) DUT (.clk(clk), .rstn(rstn),
		.ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata), .reg_err_r(reg_err),
		.analog_mv(analog_mv), .torque_mode(torque_mode),
		.zero_command_speed_mode(zcm), .servo_on(servo_on),
		.speed_select_inputs(sel), .preset_cmd_2(16'sh0064),
		.preset_cmd_3(16'sh00C8), .preset_cmd_4(16'sh012C),
		.speed_cmd_r(cmd), .speed_limit_r(lim), .est_inertia(est_inertia),
		.est_settled(est_settled), .est_excessive(est_excessive),
		.meas_valid(meas_valid), .meas_position_loop_gain(meas[0]),
		.meas_position_feedforward_gain(meas[1]),
		.meas_speed_proportional_gain(meas[2]),
		.meas_speed_integral_gain(meas[3]),
		.meas_speed_feedforward_gain(meas[4]),
		.meas_resonance_lowpass_setting(meas[5]),
		.meas_antidisturbance_gain(meas[6]), .estimate_en_r(est_en),
		.auto_gain_en_r(auto_en), .response_level_r(resp),
		.load_inertia_ratio_r(inertia), .inertia_stable_flag_r(flag),
		.position_loop_gain_r(gain[0]),
		.position_feedforward_gain_r(gain[1]),
		.speed_proportional_gain_r(gain[2]), .speed_integral_gain_r(gain[3]),
		.speed_feedforward_gain_r(gain[4]),
		.resonance_lowpass_setting_r(gain[5]),
		.antidisturbance_gain_r(gain[6]));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, d, input logic e);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
		chk(16'(reg_err), 16'(e));
	endtask
	task automatic rd(input logic [15:0] a, exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// bounded wait on the stability flag, edge-aligned for later drives
	task automatic wait_on;
		n = 0;
		while (flag !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		print_verdict;
	end
	initial
	begin
		{rstn, reg_wr, reg_rd, torque_mode, zcm, servo_on, overload} = '0;
		{reg_addr, reg_wdata, mv_set, sel} = '0;
		ce = 1'b1;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		#1;
		foreach (gain[i]) chk(gain[i], GAIN_RST[i]);
		chk(resp, RESP_RST);
		rd(ADDR_MODE, 16'h0000);
		rd(ADDR_SCALE, SCALE_RST);
		@(posedge clk);
		servo_on <= 1'b1;
		foreach (rows[i])
		begin
			@(posedge clk);
			{mv_set, torque_mode, zcm, sel} <=
				{rows[i].mv, rows[i].tq, rows[i].zc, rows[i].sel};
			repeat (3) @(posedge clk);
			#1;
			chk(cmd, rows[i].cmd);
			chk(lim, rows[i].lim);
		end
		@(posedge clk);
		{torque_mode, servo_on} <= 2'b00;
		repeat (3) @(posedge clk);
		#1;
		chk(cmd, 16'h0000);
		@(posedge clk);
		servo_on <= 1'b1;
		wr(ADDR_SCALE, 16'h2711, 1'b1);
		wr(ADDR_SCALE, 16'h2710, 1'b0);
		@(posedge clk);
		mv_set <= 16'sh2710;
		repeat (3) @(posedge clk);
		#1;
		chk(cmd, 16'h2710);
		wr(GAIN_ADDR[GAIN_KVP], 16'h2000, 1'b1);
		wr(GAIN_ADDR[GAIN_KVP], 16'h1FFF, 1'b0);
		rd(GAIN_ADDR[GAIN_KVP], 16'h1FFF);
		wr(ADDR_MODE, 16'h0003, 1'b1);
		wr(ADDR_RESP, 16'h0000, 1'b1);
		wr(ADDR_RESP, 16'h000A, 1'b0);
		wr(ADDR_STABLE, 16'h0001, 1'b1);
		wr(16'h0300, 16'h0001, 1'b1);
		rd(16'h0300, 16'h0000);
		wr(ADDR_MODE, 16'h0001, 1'b0);
		// save period of 20 cycles: nothing saved before it has run out
		repeat (20) @(posedge clk);
		#1;
		chk(inertia, INERTIA_RST);
		chk(16'(auto_en), 16'h0001);
		@(posedge clk);
		#1;
		chk(inertia, 16'h0030);
		wr(ADDR_INERTIA, 16'h0020, 1'b0);
		chk(inertia, 16'h0020);
		wr(ADDR_MODE, 16'h0002, 1'b0);
		wait_on;
		#1;
		chk({flag, est_en, inertia[13:0]}, 16'h8030);
		rd(ADDR_STABLE, 16'h0001);
		@(posedge clk);
		overload <= 1'b1;
		@(posedge clk);
		overload <= 1'b0;
		@(posedge clk);
		#1;
		chk({flag, est_en}, 16'h0001);
		wr(ADDR_MODE, 16'h0000, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		foreach (gain[i]) chk(gain[i], GAIN_RST[i] + 16'(i + 1));
		chk(16'(auto_en), 16'h0000);
		rd(GAIN_ADDR[GAIN_KVP], 16'h01F7);
		// clock enable low: write ignored, read data held from last read
		@(posedge clk);
		ce <= 1'b0;
		wr(ADDR_RESP, 16'h0003, 1'b0);
		rd(ADDR_RESP, 16'h01F7);
		@(posedge clk);
		ce <= 1'b1;
		rd(ADDR_RESP, 16'h000A);
		print_verdict;
	end
endmodule
`default_nettype wire
